// ### rx_status_cfg.svh
// Register offsets, bit positions and reset values of the receive status registers.
`ifndef RX_STATUS_CFG_SVH
`define RX_STATUS_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RX_CELL_INT_ADDR 8'h41
`define RX_SEC_ADDR 8'h45
`define RX_CELL_EN_ADDR 8'h4C

// ****************************************************************
// Receive-cell interrupt indication fields
// ****************************************************************
`define CELL_ARRIVED_BIT 3
`define IDLE_CELL_BIT 2
`define HDR_MISMATCH_BIT 1
`define FLOW_NONZERO_BIT 0
`define CELL_RSV_BIT 4
`define CELL_INT_W 4
`define CELL_DUAL_MASK 4'h0
`define CELL_EN_RESET 4'h0

// ****************************************************************
// Receive section status fields
// ****************************************************************
`define SEC_SIG_BIT 7
`define SEC_LOL_BIT 6
`define SEC_LOS_BIT 5
`define SEC_OOF_BIT 4
`define SEC_LOF_BIT 3
`define SEC_PAR_BIT 2
`define SEC_SEL_BIT 1
`define SEC_POL_BIT 0
`define SEC_SEL_RESET 1'h0
`define SEC_POL_RESET 1'h0

`endif

// ### rx_status_pkg.sv
// Types shared by the receive status register block.
package rx_status_pkg;

  // Byte-wide register value.
  typedef logic [7:0] reg8_t;

  // Register selected by the decoded address.
  typedef enum logic [1:0] {
    REG_NONE = 2'b00,
    REG_CELL_INT = 2'b01,
    REG_SEC = 2'b10,
    REG_CELL_EN = 2'b11
  } reg_sel_t;

endpackage : rx_status_pkg

// ### event_latch.sv
// Edge detection and sticky pending flags for a group of interrupt sources.
`timescale 1ns/1ns
module event_latch #(
  parameter int W = 4,
  parameter logic [W-1:0] DUAL = '0
) (
  input wire logic clk_i, // Receive clock.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic [W-1:0] src_i, // Underlying status levels.
  input wire logic [W-1:0] en_i, // Per-source enables.
  input wire logic [W-1:0] clr_i, // Per-source clear requests.
  output logic [W-1:0] set_o, // Qualified change this cycle.
  output logic [W-1:0] pend_o // Sticky pending flags.
);

  logic [W-1:0] prev_q;
  logic [W-1:0] pend_q;

  // ****************************************************************
  // Per-bit edge detection
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // Dual sources fire on any change, single ones on a rise only.
      if (DUAL[g]) begin : g_dual
        assign set_o[g] = en_i[g] & (src_i[g] ^ prev_q[g]); // [RULE5]
      end else begin : g_single
        assign set_o[g] = en_i[g] & src_i[g] & ~prev_q[g]; // [RULE6]
      end
    end
  endgenerate

  // Previous level of each source.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_q <= '0;
    end else if (ce_i) begin
      prev_q <= src_i;
    end
  end

  // Pending flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q <= '0;
    end else if (ce_i) begin
      pend_q <= (pend_q & ~clr_i) | set_o; // [RULE16]
    end
  end

  assign pend_o = pend_q;

endmodule : event_latch

// ### ref_out_gen.sv
// Selection and polarity of the receive frame reference output.
`timescale 1ns/1ns
module ref_out_gen (
  input wire logic clk_i, // Receive clock.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic octet_clk_i, // Receive octet clock level.
  input wire logic frame_pulse_i, // Frame pulse, active high.
  input wire logic sel_clk_i, // One selects the octet clock.
  input wire logic pol_high_i, // One makes the pulse active high.
  output logic ref_o // Frame reference output.
);

  logic ref_q;

  // The clock passes unchanged; the pulse takes the chosen polarity.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_q <= 1'b1;
    end else if (ce_i) begin
      if (sel_clk_i) begin
        ref_q <= octet_clk_i; // [RULE17]
      end else begin
        ref_q <= pol_high_i ? frame_pulse_i : ~frame_pulse_i; // [RULE18]
      end
    end
  end

  assign ref_o = ref_q;

endmodule : ref_out_gen

// ### rx_cell_section_status_regs.sv
// Receive-cell interrupt indication and receive section status registers.
// Contract
// [RULE1] Cell received sets bit 3 until read.
// [RULE2] Idle cell sets bit 2 until read.
// [RULE3] Header mismatch sets bit 1 until read.
// [RULE4] Nonzero flow field sets bit 0 until read.
// [RULE5] Dual sources fire on either enabled change.
// [RULE6] Single sources fire on enabled rise only.
// [RULE7] Reading an indication register clears its flags.
// [RULE8] Cell register bit 4 always reads zero.
// [RULE9] Section bit 7 shows media signal input.
// [RULE10] Section bit 6 shows clock recovery unlocked.
// [RULE11] Section bit 5 shows line signal absent.
// [RULE12] Section bit 4 shows framer unaligned.
// [RULE13] Section bit 3 shows framing lost.
// [RULE14] Section bit 2 latches section parity error.
// [RULE15] Live bits track condition without latching.
// [RULE16] Event bits hold occurrences since last read.
// [RULE17] Section bit 1 picks octet clock output.
// [RULE18] Section bit 0 sets pulse output polarity.
// [RULE19] Interrupt high while enabled flag pending.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`include "rx_status_cfg.svh"
module rx_cell_section_status_regs (
  input wire logic clk_i, // Receive clock, 250 MHz.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic ce_i, // Clock enable; low freezes all state.
  input wire logic [7:0] addr_i, // Register address.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [7:0] rdata_o, // Read data, one cycle after the strobe.
  input wire logic cell_arrived_i, // Cell received status.
  input wire logic idle_cell_arrived_i, // Idle cell received status.
  input wire logic header_mismatch_i, // Non-matching cell status.
  input wire logic flow_field_nonzero_i, // Nonzero flow control field status.
  input wire logic media_signal_present_in_i, // Signal detect from media module.
  input wire logic clock_recovery_unlocked_i, // Recovery loop out of lock.
  input wire logic line_signal_absent_i, // Loss of signal on the line.
  input wire logic framer_unaligned_i, // Framer out of frame.
  input wire logic framing_lost_i, // Loss of frame condition.
  input wire logic section_parity_error_i, // Section parity error strobe.
  input wire logic octet_clk_i, // Receive octet clock level.
  input wire logic frame_pulse_i, // Receive frame pulse, active high.
  output logic rx_frame_reference_out_o, // Frame reference output.
  output logic irq_o // Summary interrupt, active high level.
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  rx_status_pkg::reg_sel_t sel;
  logic [`CELL_INT_W-1:0] cell_src;
  logic [`CELL_INT_W-1:0] cell_en_q;
  logic [`CELL_INT_W-1:0] cell_set;
  logic [`CELL_INT_W-1:0] cell_pend;
  logic [`CELL_INT_W-1:0] cell_clr;
  logic [0:0] par_set;
  logic [0:0] par_pend;
  logic [0:0] par_clr;
  logic rx_ref_output_select_q;
  logic rx_ref_pulse_polarity_q;
  logic [4:0] sec_live;
  rx_status_pkg::reg8_t cell_view;
  rx_status_pkg::reg8_t sec_view;
  rx_status_pkg::reg8_t en_view;
  rx_status_pkg::reg8_t rdata_d;
  rx_status_pkg::reg8_t rdata_q;

  // Map the address onto one of the implemented registers.
  always_comb begin
    case (addr_i)
      `RX_CELL_INT_ADDR: sel = rx_status_pkg::REG_CELL_INT;
      `RX_SEC_ADDR: sel = rx_status_pkg::REG_SEC;
      `RX_CELL_EN_ADDR: sel = rx_status_pkg::REG_CELL_EN;
      default: sel = rx_status_pkg::REG_NONE;
    endcase
  end

  // ****************************************************************
  // Receive-cell interrupt indication
  // ****************************************************************

  // Gather the four cell status sources at their bit positions.
  always_comb begin
    cell_src = '0;
    cell_src[`CELL_ARRIVED_BIT] = cell_arrived_i; // [RULE1]
    cell_src[`IDLE_CELL_BIT] = idle_cell_arrived_i; // [RULE2]
    cell_src[`HDR_MISMATCH_BIT] = header_mismatch_i; // [RULE3]
    cell_src[`FLOW_NONZERO_BIT] = flow_field_nonzero_i; // [RULE4]
  end

  // A read clears every reported flag; writing ones also clears them.
  always_comb begin
    cell_clr = '0;
    if (rd_i && sel == rx_status_pkg::REG_CELL_INT) begin
      cell_clr = '1; // [RULE7]
    end else if (wr_i && sel == rx_status_pkg::REG_CELL_INT) begin
      cell_clr = wdata_i[`CELL_INT_W-1:0];
    end
  end

  // All four cell sources are single-event sources.
  event_latch #(
    .W(`CELL_INT_W),
    .DUAL(`CELL_DUAL_MASK)
  ) u_cell_latch (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .src_i(cell_src),
    .en_i(cell_en_q),
    .clr_i(cell_clr),
    .set_o(cell_set),
    .pend_o(cell_pend)
  );

  // Enable register, which also masks the interrupt output.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cell_en_q <= `CELL_EN_RESET;
    end else if (ce_i && wr_i && sel == rx_status_pkg::REG_CELL_EN) begin
      cell_en_q <= wdata_i[`CELL_INT_W-1:0];
    end
  end

  // Upper bits, reserved bit 4 among them, read as zero.
  assign cell_view = {4'h0, cell_pend}; // [RULE8]
  assign en_view = {4'h0, cell_en_q};

  // ****************************************************************
  // Receive section overhead status
  // ****************************************************************

  // Live conditions pass straight through to the read path.
  assign sec_live = {
    media_signal_present_in_i, // [RULE9]
    clock_recovery_unlocked_i, // [RULE10]
    line_signal_absent_i, // [RULE11]
    framer_unaligned_i, // [RULE12]
    framing_lost_i // [RULE13]
  }; // [RULE15]

  // The parity flag clears on a read of the section register.
  assign par_clr[0] = rd_i && sel == rx_status_pkg::REG_SEC; // [RULE7]

  // Parity errors latch until the section register is read.
  event_latch #(
    .W(1),
    .DUAL(1'b0)
  ) u_par_latch (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .src_i(section_parity_error_i),
    .en_i(1'b1),
    .clr_i(par_clr),
    .set_o(par_set),
    .pend_o(par_pend) // [RULE14]
  );

  // Output select and polarity control bits.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_ref_output_select_q <= `SEC_SEL_RESET;
      rx_ref_pulse_polarity_q <= `SEC_POL_RESET;
    end else if (ce_i && wr_i && sel == rx_status_pkg::REG_SEC) begin
      rx_ref_output_select_q <= wdata_i[`SEC_SEL_BIT]; // [RULE17]
      rx_ref_pulse_polarity_q <= wdata_i[`SEC_POL_BIT]; // [RULE18]
    end
  end

  // Assemble the section register as software sees it.
  always_comb begin
    sec_view = '0;
    sec_view[`SEC_SIG_BIT:`SEC_LOF_BIT] = sec_live;
    sec_view[`SEC_PAR_BIT] = par_pend[0];
    sec_view[`SEC_SEL_BIT] = rx_ref_output_select_q;
    sec_view[`SEC_POL_BIT] = rx_ref_pulse_polarity_q;
  end

  // ****************************************************************
  // Frame reference output
  // ****************************************************************

  // Drives the reference pin from the clock or the shaped pulse.
  ref_out_gen u_ref (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .octet_clk_i(octet_clk_i),
    .frame_pulse_i(frame_pulse_i),
    .sel_clk_i(rx_ref_output_select_q),
    .pol_high_i(rx_ref_pulse_polarity_q),
    .ref_o(rx_frame_reference_out_o)
  );

  // ****************************************************************
  // Read path and interrupt
  // ****************************************************************

  // Choose the value returned for a read; unmapped reads return zero.
  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      case (sel)
        rx_status_pkg::REG_CELL_INT: rdata_d = cell_view;
        rx_status_pkg::REG_SEC: rdata_d = sec_view;
        rx_status_pkg::REG_CELL_EN: rdata_d = en_view;
        default: rdata_d = '0;
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= '0;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // Level interrupt while any enabled cell flag is pending; the parity flag never raises it.
  assign irq_o = |(cell_pend & cell_en_q); // [RULE19]

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // Read of the cell indication register.
  sequence s_read_cell;
    ce_i && rd_i && sel == rx_status_pkg::REG_CELL_INT;
  endsequence

  // Read of the section register.
  sequence s_read_sec;
    ce_i && rd_i && sel == rx_status_pkg::REG_SEC;
  endsequence

  // Write of the cell indication register.
  sequence s_write_cell;
    ce_i && wr_i && sel == rx_status_pkg::REG_CELL_INT;
  endsequence

  // Enabled rise of the cell received source.
  sequence s_cell_rise;
    ce_i && cell_arrived_i && !$past(cell_arrived_i) && cell_en_q[`CELL_ARRIVED_BIT]
      && $past(ce_i);
  endsequence

  AST_CELL_STICKY: assert property ( // [RULE1]
    s_cell_rise ##1 (!ce_i || !((rd_i || wr_i) && sel == rx_status_pkg::REG_CELL_INT))
      |-> cell_pend[`CELL_ARRIVED_BIT] ##1 cell_pend[`CELL_ARRIVED_BIT])
    else $error("cell received flag not held");

  AST_IDLE_SET: assert property ( // [RULE2]
    ce_i && cell_set[`IDLE_CELL_BIT] |=> cell_pend[`IDLE_CELL_BIT])
    else $error("idle cell flag not set");

  AST_SINGLE_FALL: assert property ( // [RULE6]
    ce_i && $past(ce_i) && !idle_cell_arrived_i && $past(idle_cell_arrived_i)
      |-> !cell_set[`IDLE_CELL_BIT])
    else $error("single event fired on a fall");

  AST_READ_CLEARS: assert property ( // [RULE7]
    s_read_cell ##0 (cell_set == '0) |=> cell_pend == '0 ##0 rdata_o == $past(cell_view))
    else $error("read did not clear and report cell flags");

  AST_SET_WINS: assert property ( // [RULE16]
    s_read_cell ##0 cell_set[`HDR_MISMATCH_BIT] |=> cell_pend[`HDR_MISMATCH_BIT])
    else $error("event lost during read clear");

  AST_RSV_ZERO: assert property ( // [RULE8]
    s_read_cell |=> rdata_o[7:`CELL_RSV_BIT] == 4'h0)
    else $error("reserved cell bits not zero");

  AST_LIVE_BITS: assert property ( // [RULE15]
    s_read_sec |=> rdata_o[`SEC_SIG_BIT:`SEC_LOF_BIT] == $past(sec_live))
    else $error("live section bits not current");

  AST_PAR_LATCH: assert property ( // [RULE14]
    ce_i && par_set[0] ##1 !(ce_i && rd_i && sel == rx_status_pkg::REG_SEC) && ce_i
      ##1 s_read_sec |=> rdata_o[`SEC_PAR_BIT])
    else $error("parity error not reported on read");

  AST_REF_CLOCK: assert property ( // [RULE17]
    ce_i && rx_ref_output_select_q |=> rx_frame_reference_out_o == $past(octet_clk_i))
    else $error("reference output not the octet clock");

  AST_REF_LOW: assert property ( // [RULE18]
    ce_i && !rx_ref_output_select_q && !rx_ref_pulse_polarity_q
      |=> rx_frame_reference_out_o == !$past(frame_pulse_i))
    else $error("frame pulse polarity wrong");

  AST_IRQ_RAISE: assert property ( // [RULE19]
    ce_i && cell_set[`FLOW_NONZERO_BIT] ##1 cell_en_q[`FLOW_NONZERO_BIT] |-> irq_o)
    else $error("interrupt not raised for pending flag");

  AST_IRQ_DROP: assert property ( // [RULE19]
    s_read_cell ##0 (cell_set == '0) ##0 !(wr_i && sel == rx_status_pkg::REG_CELL_EN)
      |=> !irq_o)
    else $error("interrupt held after clearing read");

  AST_RDATA_ONE: assert property (
    ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data stood beyond one cycle");

  AST_W1C_CLEAR: assert property ( // [RULE7]
    s_write_cell ##0 wdata_i[`FLOW_NONZERO_BIT] ##0 !cell_set[`FLOW_NONZERO_BIT]
      |=> !cell_pend[`FLOW_NONZERO_BIT])
    else $error("written one did not clear the flag");

  AST_PAR_CLEAR: assert property ( // [RULE7]
    s_read_sec ##0 !par_set[0] |=> !par_pend[0])
    else $error("section read did not clear the parity flag");

  AST_MASKED_DROP: assert property ( // [RULE6]
    ce_i && cell_en_q == '0 && cell_pend == '0 |=> cell_pend == '0)
    else $error("disabled source set a flag");

  AST_CTRL_STORE: assert property ( // [RULE17]
    ce_i && wr_i && sel == rx_status_pkg::REG_SEC
      |=> rx_ref_output_select_q == $past(wdata_i[`SEC_SEL_BIT]))
    else $error("output select not stored");

  AST_REF_HIGH: assert property ( // [RULE18]
    ce_i && !rx_ref_output_select_q && rx_ref_pulse_polarity_q
      |=> rx_frame_reference_out_o == $past(frame_pulse_i))
    else $error("active high frame pulse wrong");

  AST_FREEZE: assert property (
    !ce_i |=> $stable(cell_pend) && $stable(par_pend) && $stable(rdata_o)
      && $stable(rx_frame_reference_out_o))
    else $error("state changed while the clock enable was low");

  AST_IRQ_MASKED: assert property ( // [RULE19]
    cell_en_q == '0 |-> !irq_o)
    else $error("interrupt raised with every source disabled");

endmodule : rx_cell_section_status_regs

// ### tb_rx_cell_section_status_regs.sv
// Self-checking testbench of the receive status register block.
`timescale 1ns/1ns
`include "rx_status_cfg.svh"
module testbench;
  // ****************************************************************
  // Stimulus signals
  // ****************************************************************
  logic clk_i;
  logic arst_n;
  logic ce;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [3:0] cell_src;
  logic [4:0] live;
  logic par_err;
  logic octet_clk;
  logic frame_pulse;
  logic ref_out;
  logic irq;
  int n_fail;
  int total_checks;
  int cycles;

  // Cell sources are packed as bit 3 cell, 2 idle, 1 mismatch, 0 flow field.
  rx_cell_section_status_regs dut (
    .clk_i(clk_i),
    .arst_n_i(arst_n),
    .ce_i(ce),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .cell_arrived_i(cell_src[3]),
    .idle_cell_arrived_i(cell_src[2]),
    .header_mismatch_i(cell_src[1]),
    .flow_field_nonzero_i(cell_src[0]),
    .media_signal_present_in_i(live[4]),
    .clock_recovery_unlocked_i(live[3]),
    .line_signal_absent_i(live[2]),
    .framer_unaligned_i(live[1]),
    .framing_lost_i(live[0]),
    .section_parity_error_i(par_err),
    .octet_clk_i(octet_clk),
    .frame_pulse_i(frame_pulse),
    .rx_frame_reference_out_o(ref_out),
    .irq_o(irq)
  );

  // The clock toggles every half period of 2 ns.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // A hang is cut short after a fixed number of cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compares a seen value with the expected one and counts the result.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // One-cycle write strobe beside address and data.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  // One-cycle read strobe; data are taken in the cycle after it.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Lets a number of clock edges pass.
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, and read data standing for one cycle only.
  task automatic t_reset();
    logic [7:0] d;
    rd_reg(`RX_CELL_INT_ADDR, d);
    chk(d, 8'h00);
    @(posedge clk_i);
    #1 chk(rdata, 8'h00);
    rd_reg(`RX_SEC_ADDR, d);
    chk(d, 8'h00);
    rd_reg(`RX_CELL_EN_ADDR, d);
    chk(d, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask : t_reset

  // Each enabled cell source sets its own bit once; a fall sets nothing.
  task automatic t_cell_events();
    logic [7:0] d;
    wr_reg(`RX_CELL_EN_ADDR, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      cell_src <= 4'h1 << i;
      idle(2);
      chk({7'h00, irq}, 8'h01);
      rd_reg(`RX_CELL_INT_ADDR, d);
      chk(d, 8'h01 << i);
      chk({7'h00, irq}, 8'h00);
      @(posedge clk_i);
      cell_src <= 4'h0;
      idle(2);
      rd_reg(`RX_CELL_INT_ADDR, d);
      chk(d, 8'h00);
    end
    // All four at once are all reported and cleared by one read.
    @(posedge clk_i);
    cell_src <= 4'hF;
    idle(2);
    rd_reg(`RX_CELL_INT_ADDR, d);
    chk(d, 8'h0F);
    rd_reg(`RX_CELL_INT_ADDR, d);
    chk(d, 8'h00);
    @(posedge clk_i);
    cell_src <= 4'h0;
    idle(1);
  endtask : t_cell_events

  // A rise while disabled is dropped and not reported after enabling.
  task automatic t_masked();
    logic [7:0] d;
    wr_reg(`RX_CELL_EN_ADDR, 8'h00);
    @(posedge clk_i);
    cell_src <= 4'h8;
    idle(2);
    chk({7'h00, irq}, 8'h00);
    wr_reg(`RX_CELL_EN_ADDR, 8'h08);
    idle(2);
    chk({7'h00, irq}, 8'h00);
    rd_reg(`RX_CELL_INT_ADDR, d);
    chk(d, 8'h00);
    rd_reg(`RX_CELL_EN_ADDR, d);
    chk(d, 8'h08);
    @(posedge clk_i);
    cell_src <= 4'h0;
    idle(1);
  endtask : t_masked

  // A written one clears its flag; a low clock enable holds back a rise.
  task automatic t_w1c_freeze();
    logic [7:0] d;
    wr_reg(`RX_CELL_EN_ADDR, 8'h0F);
    @(posedge clk_i);
    cell_src <= 4'h3;
    idle(2);
    wr_reg(`RX_CELL_INT_ADDR, 8'h01);
    rd_reg(`RX_CELL_INT_ADDR, d);
    chk(d, 8'h02);
    @(posedge clk_i);
    ce <= 1'b0;
    cell_src <= 4'h4;
    idle(3);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk_i);
    ce <= 1'b1;
    idle(2);
    chk({7'h00, irq}, 8'h01);
    rd_reg(`RX_CELL_INT_ADDR, d);
    chk(d, 8'h04);
    @(posedge clk_i);
    cell_src <= 4'h0;
    idle(1);
  endtask : t_w1c_freeze

  // Live section bits follow their inputs without latching.
  task automatic t_section_live();
    logic [7:0] d;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      live <= 5'h01 << k;
      idle(1);
      rd_reg(`RX_SEC_ADDR, d);
      chk(d, 8'h08 << k);
      @(posedge clk_i);
      live <= 5'h00;
      idle(1);
      rd_reg(`RX_SEC_ADDR, d);
      chk(d, 8'h00);
    end
  endtask : t_section_live

  // A one-cycle parity error is held until the register is read.
  task automatic t_parity();
    logic [7:0] d;
    @(posedge clk_i);
    par_err <= 1'b1;
    @(posedge clk_i);
    par_err <= 1'b0;
    idle(4);
    chk({7'h00, irq}, 8'h00);
    rd_reg(`RX_SEC_ADDR, d);
    chk(d, 8'h04);
    rd_reg(`RX_SEC_ADDR, d);
    chk(d, 8'h00);
  endtask : t_parity

  // Reference output source and polarity for each setting.
  task automatic t_ref_out();
    logic [7:0] d;
    logic [7:0] mode;
    logic e;
    for (int m = 0; m < 3; m++) begin
      mode = 8'h02 >> m;
      wr_reg(`RX_SEC_ADDR, mode);
      for (int v = 0; v < 2; v++) begin
        @(posedge clk_i);
        octet_clk <= v[0];
        frame_pulse <= ~v[0];
        e = (m == 0) ? v[0] : ((m == 1) ? ~v[0] : v[0]);
        @(posedge clk_i);
        #1 chk({7'h00, ref_out}, {7'h00, e});
      end
    end
    wr_reg(`RX_SEC_ADDR, 8'hFF);
    rd_reg(`RX_SEC_ADDR, d);
    chk(d, 8'h03);
    wr_reg(`RX_SEC_ADDR, 8'h00);
  endtask : t_ref_out

  // An unmapped address ignores writes and reads as zero.
  task automatic t_unmapped();
    logic [7:0] d;
    wr_reg(8'h50, 8'hFF);
    rd_reg(8'h50, d);
    chk(d, 8'h00);
  endtask : t_unmapped

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Inputs get values at time zero, reset is held for 12 cycles.
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cell_src = 4'h0;
    live = 5'h00;
    par_err = 1'b0;
    octet_clk = 1'b0;
    frame_pulse = 1'b0;
    n_fail = 0;
    total_checks = 0;
    cycles = 0;
    repeat (12) @(posedge clk_i);
    arst_n <= 1'b1;
    #1 chk({7'h00, ref_out}, 8'h01);
    t_reset();
    t_cell_events();
    t_masked();
    t_w1c_freeze();
    t_section_live();
    t_parity();
    t_ref_out();
    t_unmapped();
    close_out();
  end
endmodule : testbench
